// File: rtl/cfg_req_builder.sv
/*
  Request builder: latches one configuration write request, placing
  the low bytes of the data word in the addressed lanes and deriving
  the byte enables.
  Assumes the caller loads it only with a span that is legal.
*/
`timescale 1ns/10ps
module cfg_req_builder
  import cfg_write_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   nrst,
  input  wire logic                   load,
  input  wire logic [7:0]             tag,
  input  wire logic [31:0]            target,
  input  wire logic [2:0]             writeByteCount,
  input  wire logic [31:0]            wdata,
  output      cfg_write_pkg::cfg_req_t req
);
  import cfg_write_pkg::*;

  cfg_req_t   req_r;
  cfg_req_t   req_nxt;
  logic [1:0] offset;

  assign offset = target[TGT_ADDR_LSB +: 2];

  // ---------------------------------------------------------------
  // Next request
  // ---------------------------------------------------------------
  always_comb begin
    req_nxt = req_r;
    if (load) begin
      req_nxt.tag     = tag;
      req_nxt.bus     = target[TGT_BUS_LSB +: 8];
      req_nxt.dev     = target[TGT_DEV_LSB +: 5];
      req_nxt.fn      = target[TGT_FN_LSB +: 3];
      req_nxt.regNum  = target[TGT_ADDR_LSB + 2 +: 10];
      req_nxt.firstBe = byteEnables(offset, writeByteCount);
      req_nxt.data    = laneData(wdata, offset, writeByteCount);
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      req_r <= '0;
    end else begin
      req_r <= req_nxt;
    end
  end

  assign req = req_r;

endmodule // cfg_req_builder

// File: rtl/cfg_write_pkg.sv
/*
  Constants, types and helpers for the configuration write requester:
  register offsets and field positions, completion status codes, the
  request and completion carriers, and the byte lane functions.
  Assumes a 32-bit register port and one clock domain.
*/
package cfg_write_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam int unsigned REG_ADDR_W = 8;
  localparam int unsigned REG_DATA_W = 32;

  localparam logic [7:0] OFS_CTRL       = 8'h00;
  localparam logic [7:0] OFS_TARGET     = 8'h04;
  localparam logic [7:0] OFS_BYTE_COUNT = 8'h08;
  localparam logic [7:0] OFS_WDATA      = 8'h0C;
  localparam logic [7:0] OFS_STATUS     = 8'h10;
  localparam logic [7:0] OFS_IRQ_STAT   = 8'h14;
  localparam logic [7:0] OFS_IRQ_CLR    = 8'h18;
  localparam logic [7:0] OFS_IRQ_EN     = 8'h1C;

  // Control fields
  localparam int unsigned CTRL_GO_BIT   = 0;
  localparam int unsigned CTRL_WAIT_BIT = 1;

  // Target fields: bus, device, function, byte address
  localparam int unsigned TGT_BUS_LSB  = 24;
  localparam int unsigned TGT_DEV_LSB  = 19;
  localparam int unsigned TGT_FN_LSB   = 16;
  localparam int unsigned TGT_ADDR_LSB = 0;

  // Status fields
  localparam int unsigned ST_BUSY_BIT   = 0;
  localparam int unsigned ST_CPL_LSB    = 1;
  localparam int unsigned ST_BADREQ_BIT = 4;
  localparam int unsigned ST_WAIT_BIT   = 5;

  // Interrupt bits
  localparam int unsigned IRQ_W          = 3;
  localparam int unsigned IRQ_DONE_BIT   = 0;
  localparam int unsigned IRQ_FAIL_BIT   = 1;
  localparam int unsigned IRQ_BADREQ_BIT = 2;

  // Reset values and the word size in bytes
  localparam logic [31:0] TARGET_RST = 32'h0000_0000;
  localparam logic [2:0]  COUNT_RST  = 3'h4;
  localparam logic [31:0] WDATA_RST  = 32'h0000_0000;
  localparam logic [7:0]  TAG_RST    = 8'h00;
  localparam logic [2:0]  WORD_BYTES = 3'h4;

  // ---------------------------------------------------------------
  // Completion status codes
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    CPL_SC  = 3'h0,
    CPL_UR  = 3'h1,
    CPL_CRS = 3'h2,
    CPL_CA  = 3'h4
  } cpl_status_t;

  // ---------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  tag;
    logic [7:0]  bus;
    logic [4:0]  dev;
    logic [2:0]  fn;
    logic [9:0]  regNum;
    logic [3:0]  firstBe;
    logic [31:0] data;
  } cfg_req_t;

  typedef struct packed {
    logic [7:0] tag;
    logic [2:0] status;
  } cfg_cpl_t;

  // ---------------------------------------------------------------
  // Byte lane helpers
  // ---------------------------------------------------------------
  function automatic logic spanLegal(input logic [1:0] off,
                                     input logic [2:0] cnt);
    logic [3:0] last;
    last = {2'b00, off} + {1'b0, cnt};
    return (cnt != 3'h0) && (cnt <= WORD_BYTES) && (last <= 4'h4);
  endfunction

  function automatic logic [3:0] byteEnables(input logic [1:0] off,
                                             input logic [2:0] cnt);
    logic [3:0] lenBits;
    case (cnt)
      3'h1:    lenBits = 4'h1;
      3'h2:    lenBits = 4'h3;
      3'h3:    lenBits = 4'h7;
      3'h4:    lenBits = 4'hF;
      default: lenBits = 4'h0;
    endcase
    return 4'(lenBits << off);
  endfunction

  function automatic logic [31:0] laneData(input logic [31:0] data,
                                           input logic [1:0]  off,
                                           input logic [2:0]  cnt);
    logic [31:0] kept;
    kept = 32'h0000_0000;
    for (int i = 0; i < 4; i++) begin
      if (3'(i) < cnt) begin
        kept[8*i +: 8] = data[8*i +: 8];
      end
    end
    return 32'(kept << {off, 3'b000});
  endfunction

endpackage

// File: rtl/config_write_requester.sv
/*
  Configuration write requester: software sets target, byte count and
  data over a plain register port, then starts a write in waiting or
  non-waiting mode. The request goes to the virtual-channel port; in
  waiting mode the matching completion ends the operation.
  A GO while busy is ignored; an illegal span is flagged, not sent.
  Read data stand for one cycle after the read strobe, else zero.
  Assumes the virtual-channel port and completions share clk.
  Assumes software leaves target, count and data alone while busy.
*/
// The plain strobed port and the register offsets are this design's own decisions.
`timescale 1ns/10ps
module config_write_requester
  import cfg_write_pkg::*;
(
  input  wire logic                    clk,
  input  wire logic                    nrst,
  input  wire logic [7:0]              regAddr,
  input  wire logic [31:0]             regWdata,
  input  wire logic                    regWrite,
  input  wire logic                    regRead,
  output      logic [31:0]             regRdata,
  output      logic                    vcReqValid,
  input  wire logic                    vcReqReady,
  output      cfg_write_pkg::cfg_req_t vcReq,
  input  wire logic                    vcCplValid,
  input  wire cfg_write_pkg::cfg_cpl_t vcCpl,
  output      logic                    irq
);
  import cfg_write_pkg::*;

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    IDLE,
    ISSUE,
    AWAIT_CPL
  } state_t;

  state_t             state_r;
  state_t             state_nxt;
  logic               waitMode_r;
  logic               waitMode_nxt;
  logic [31:0]        target_r;
  logic [31:0]        target_nxt;
  logic [2:0]         writeByteCount_r;
  logic [2:0]         writeByteCount_nxt;
  logic [31:0]        wdata_r;
  logic [31:0]        wdata_nxt;
  logic [7:0]         tag_r;
  logic [7:0]         tag_nxt;
  logic [2:0]         cplStatus_r;
  logic [2:0]         cplStatus_nxt;
  logic               badReq_r;
  logic               badReq_nxt;
  logic [IRQ_W-1:0]   irqStat_r;
  logic [IRQ_W-1:0]   irqStat_nxt;
  logic [IRQ_W-1:0]   irqEn_r;
  logic [IRQ_W-1:0]   irqEn_nxt;
  logic [31:0]        rdata_r;
  logic [31:0]        rdata_nxt;

  logic               wrCtrl;
  logic               goReq;
  logic               goLegal;
  logic               load;
  logic               accepted;
  logic               cplMatch;
  logic [IRQ_W-1:0]   irqSet;
  logic [IRQ_W-1:0]   irqClr;
  logic [31:0]        statusWord;
  logic               busy;

  // ---------------------------------------------------------------
  // Request builder
  // ---------------------------------------------------------------
  cfg_req_builder cfg_req_builder_inst (
    .clk            (clk),
    .nrst           (nrst),
    .load           (load),
    .tag            (tag_r),
    .target         (target_r),
    .writeByteCount (writeByteCount_r),
    .wdata          (wdata_r),
    .req            (vcReq)
  );

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  assign wrCtrl   = regWrite && (regAddr == OFS_CTRL);
  assign goReq    = wrCtrl && regWdata[CTRL_GO_BIT] && (state_r == IDLE);
  assign goLegal  = spanLegal(target_r[TGT_ADDR_LSB +: 2],
                              writeByteCount_r);
  assign load     = goReq && goLegal;
  assign accepted = vcReqValid && vcReqReady;
  assign cplMatch = vcCplValid && (vcCpl.tag == vcReq.tag);

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  always_comb begin
    state_nxt     = state_r;
    waitMode_nxt  = waitMode_r;
    tag_nxt       = tag_r;
    cplStatus_nxt = cplStatus_r;
    badReq_nxt    = badReq_r;
    irqSet        = '0;
    unique case (state_r)
      IDLE: begin
        if (goReq) begin
          badReq_nxt = !goLegal;
          if (goLegal) begin
            waitMode_nxt = regWdata[CTRL_WAIT_BIT];
            state_nxt    = ISSUE;
          end else begin
            irqSet[IRQ_BADREQ_BIT] = 1'b1;
          end
        end
      end
      ISSUE: begin
        if (accepted) begin
          tag_nxt = tag_r + 8'h01;
          if (waitMode_r) begin
            state_nxt = AWAIT_CPL;
          end else begin
            state_nxt            = IDLE;
            irqSet[IRQ_DONE_BIT] = 1'b1;
          end
        end
      end
      AWAIT_CPL: begin
        if (cplMatch) begin
          state_nxt            = IDLE;
          cplStatus_nxt        = vcCpl.status;
          irqSet[IRQ_DONE_BIT] = 1'b1;
          if (vcCpl.status != CPL_SC) begin
            irqSet[IRQ_FAIL_BIT] = 1'b1;
          end
        end
      end
      default: begin
        state_nxt = IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_r     <= IDLE;
      waitMode_r  <= 1'b0;
      tag_r       <= TAG_RST;
      cplStatus_r <= CPL_SC;
      badReq_r    <= 1'b0;
    end else begin
      state_r     <= state_nxt;
      waitMode_r  <= waitMode_nxt;
      tag_r       <= tag_nxt;
      cplStatus_r <= cplStatus_nxt;
      badReq_r    <= badReq_nxt;
    end
  end

  assign vcReqValid = (state_r == ISSUE);

  // ---------------------------------------------------------------
  // Software registers
  // ---------------------------------------------------------------
  always_comb begin
    target_nxt         = target_r;
    writeByteCount_nxt = writeByteCount_r;
    wdata_nxt          = wdata_r;
    if (regWrite) begin
      unique case (regAddr)
        OFS_TARGET: begin
          target_nxt = regWdata;
        end
        OFS_BYTE_COUNT: begin
          writeByteCount_nxt = regWdata[2:0];
        end
        OFS_WDATA: begin
          wdata_nxt = regWdata;
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      target_r         <= TARGET_RST;
      writeByteCount_r <= COUNT_RST;
      wdata_r          <= WDATA_RST;
    end else begin
      target_r         <= target_nxt;
      writeByteCount_r <= writeByteCount_nxt;
      wdata_r          <= wdata_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Interrupts
  // ---------------------------------------------------------------
  always_comb begin
    irqEn_nxt = irqEn_r;
    irqClr    = '0;
    if (regWrite && (regAddr == OFS_IRQ_EN)) begin
      irqEn_nxt = regWdata[IRQ_W-1:0];
    end
    if (regWrite && (regAddr == OFS_IRQ_CLR)) begin
      irqClr = regWdata[IRQ_W-1:0];
    end
    // Set wins over a clear in the same cycle
    irqStat_nxt = (irqStat_r & ~irqClr) | irqSet;
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      irqEn_r   <= '0;
      irqStat_r <= '0;
    end else begin
      irqEn_r   <= irqEn_nxt;
      irqStat_r <= irqStat_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Status word
  // ---------------------------------------------------------------
  assign busy = (state_r != IDLE);

  always_comb begin
    statusWord                  = '0;
    statusWord[ST_BUSY_BIT]     = busy;
    statusWord[ST_CPL_LSB +: 3] = cplStatus_r;
    statusWord[ST_BADREQ_BIT]   = badReq_r;
    statusWord[ST_WAIT_BIT]     = waitMode_r;
  end

  // ---------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------
  always_comb begin
    rdata_nxt = '0;
    if (regRead) begin
      unique case (regAddr)
        OFS_CTRL: begin
          rdata_nxt[CTRL_WAIT_BIT] = waitMode_r;
        end
        OFS_TARGET: begin
          rdata_nxt = target_r;
        end
        OFS_BYTE_COUNT: begin
          rdata_nxt[2:0] = writeByteCount_r;
        end
        OFS_WDATA: begin
          rdata_nxt = wdata_r;
        end
        OFS_STATUS: begin
          rdata_nxt = statusWord;
        end
        OFS_IRQ_STAT: begin
          rdata_nxt[IRQ_W-1:0] = irqStat_r;
        end
        OFS_IRQ_EN: begin
          rdata_nxt[IRQ_W-1:0] = irqEn_r;
        end
        default: begin
          rdata_nxt = '0;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      rdata_r <= '0;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign irq      = |(irqStat_r & irqEn_r);
  assign regRdata = rdata_r;

endmodule // config_write_requester

// File: tb/config_write_requester_sva.sv
/* Port checker for the configuration write requester, with its bind.
   Assumes one clock and the package constants. */
`timescale 1ns/10ps
module config_write_requester_sva
  import cfg_write_pkg::*;
(
  input wire logic                    clk,
  input wire logic                    nrst,
  input wire logic [7:0]              regAddr,
  input wire logic [31:0]             regWdata,
  input wire logic                    regWrite,
  input wire logic                    regRead,
  input wire logic [31:0]             regRdata,
  input wire logic                    vcReqValid,
  input wire logic                    vcReqReady,
  input wire cfg_write_pkg::cfg_req_t vcReq,
  input wire logic                    vcCplValid,
  input wire cfg_write_pkg::cfg_cpl_t vcCpl,
  input wire logic                    irq
);
  logic [31:0] tgt_r;
  logic [31:0] wd_r;
  logic [2:0]  cnt_r;
  logic [2:0]  code_r;
  logic [7:0]  tag_r;
  logic        mode_r;
  logic        pend_r;
  logic        acc;
  logic        go;
  logic        legal;
  logic        busy;
  logic [3:0]  beExp;
  logic [31:0] dExp;
  // ----------------------------------------
  // Shadow of the programmed request
  // ----------------------------------------
  assign acc = vcReqValid && vcReqReady;
  assign go = regWrite && regAddr == OFS_CTRL && regWdata[CTRL_GO_BIT];
  assign legal = cnt_r != 3'h0 && {1'b0, cnt_r} + {2'h0, tgt_r[1:0]} <= 4'h4;
  assign busy = vcReqValid || pend_r;
  assign beExp = 4'(((5'h01 << cnt_r) - 5'h01) << tgt_r[1:0]);
  assign dExp = 32'((wd_r & ~(32'hFFFF_FFFF << {cnt_r, 3'h0}))
                << {tgt_r[1:0], 3'h0});
  always_ff @(posedge clk) begin
    if (!nrst) begin
      tgt_r <= TARGET_RST;
      wd_r <= WDATA_RST;
      cnt_r <= COUNT_RST;
      code_r <= 3'h0;
      tag_r <= TAG_RST;
      mode_r <= 1'b0;
      pend_r <= 1'b0;
    end else begin
      if (regWrite && regAddr == OFS_TARGET) tgt_r <= regWdata;
      if (regWrite && regAddr == OFS_WDATA) wd_r <= regWdata;
      if (regWrite && regAddr == OFS_BYTE_COUNT) cnt_r <= regWdata[2:0];
      if (go && !busy) mode_r <= regWdata[CTRL_WAIT_BIT];
      if (acc) tag_r <= tag_r + 8'h01;
      if (acc) pend_r <= mode_r;
      if (pend_r && vcCplValid && vcCpl.tag == vcReq.tag) begin
        pend_r <= 1'b0;
        code_r <= vcCpl.status;
      end
    end
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  req_hold_a: assert property (vcReqValid && !vcReqReady |=>
    vcReqValid && $stable(vcReq)) else $error("request changed unaccepted");
  req_start_a: assert property (go && legal && !busy |=> vcReqValid)
    else $error("no request after go");
  bad_span_a: assert property (go && !legal && !busy |=> !vcReqValid)
    else $error("illegal span issued");
  lane_data_a: assert property (vcReqValid |-> vcReq.data == dExp)
    else $error("request data lanes wrong");
  byte_en_a: assert property (vcReqValid |-> vcReq.firstBe == beExp)
    else $error("byte enables wrong");
  target_id_a: assert property (vcReqValid |-> vcReq.bus == tgt_r[31:24] &&
    vcReq.dev == tgt_r[23:19] && vcReq.fn == tgt_r[18:16] &&
    vcReq.regNum == tgt_r[11:2]) else $error("target fields wrong");
  tag_step_a: assert property (vcReqValid |-> vcReq.tag == tag_r)
    else $error("tag sequence wrong");
  status_read_a: assert property (regRead && regAddr == OFS_STATUS |=>
    regRdata[0] == $past(busy) && regRdata[3:1] == $past(code_r))
    else $error("status busy or code wrong");
  one_out_a: assert property (acc |=> !vcReqValid)
    else $error("request stayed after accept");
  irq_mask_a: assert property (regWrite && regAddr == OFS_IRQ_EN &&
    regWdata[2:0] == 3'h0 |=> !irq) else $error("irq while masked");
  rdata_idle_a: assert property (!regRead |=> regRdata == 32'h0)
    else $error("read data outside read slot");
  cover property (acc && mode_r);
  cover property (acc && !mode_r);
  cover property (pend_r && vcCplValid && vcCpl.status != 3'h0);
  cover property (go && !legal);
endmodule // config_write_requester_sva

bind config_write_requester config_write_requester_sva
  config_write_requester_sva_inst (
  .clk(clk), .nrst(nrst), .regAddr(regAddr), .regWdata(regWdata),
  .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
  .vcReqValid(vcReqValid), .vcReqReady(vcReqReady), .vcReq(vcReq),
  .vcCplValid(vcCplValid), .vcCpl(vcCpl), .irq(irq)
);

// File: tb/test_config_write_requester.sv
/* Self-checking bench for the requester against the target model.
   Assumes the package, the design and vc_partner are compiled first. */
`timescale 1ns/10ps
module test_config_write_requester;
  import cfg_write_pkg::*;
  logic        clk;
  logic        nrst;
  logic [7:0]  regAddr;
  logic [31:0] regWdata;
  logic        regWrite;
  logic        regRead;
  logic [31:0] regRdata;
  logic        vcReqValid;
  logic        vcReqReady;
  cfg_req_t    vcReq;
  logic        vcCplValid;
  cfg_cpl_t    vcCpl;
  logic        irq;
  logic        slow;
  logic [2:0]  cplCode;
  logic [15:0] lfsr;
  logic [7:0]  tagExp;
  logic [2:0]  lastCode;
  logic [2:0]  irqEn;
  cfg_req_t    reqExp;
  int          n_mismatch;
  int          n_compared;
  int          nGo;
  int          nAcc;
  cpl_status_t codes[4] = '{CPL_SC, CPL_UR, CPL_CRS, CPL_CA};

  config_write_requester config_write_requester_inst (
    .clk(clk), .nrst(nrst), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
    .vcReqValid(vcReqValid), .vcReqReady(vcReqReady), .vcReq(vcReq),
    .vcCplValid(vcCplValid), .vcCpl(vcCpl), .irq(irq));
  vc_partner vc_partner_inst (
    .clk(clk), .nrst(nrst), .slow(slow), .cplCode(cplCode),
    .vcReqValid(vcReqValid), .vcReq(vcReq), .vcReqReady(vcReqReady),
    .vcCplValid(vcCplValid), .vcCpl(vcCpl));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [15:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr;
  endfunction
  function automatic cfg_req_t expReq(input logic [7:0] t,
      input logic [31:0] g, input logic [2:0] n, input logic [31:0] d);
    cfg_req_t r;
    r = '0;
    r.tag = t;
    r.bus = g[31:24];
    r.dev = g[23:19];
    r.fn = g[18:16];
    r.regNum = g[11:2];
    for (int i = 0; i < 4; i++) begin
      if (i >= g[1:0] && i < g[1:0] + n) begin
        r.firstBe[i] = 1'b1;
        r.data[8*i +: 8] = d[8*(i-g[1:0]) +: 8];
      end
    end
    return r;
  endfunction
  task automatic chk(input string what, input logic [71:0] exp, got);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    #1 d = regRdata;
  endtask
  task automatic op(input logic [31:0] g, input logic [2:0] n,
      input logic [31:0] d, input logic w, input logic [2:0] c);
    logic [31:0] v;
    logic        ok;
    logic [2:0]  st;
    ok = n != 3'h0 && g[1:0] + n <= 4;
    cplCode <= c;
    wr(OFS_TARGET, g);
    wr(OFS_BYTE_COUNT, {29'h0, n});
    wr(OFS_WDATA, d);
    reqExp = expReq(tagExp, g, n, d);
    wr(OFS_CTRL, {30'h0, w, 1'b1});
    v = 32'h1;
    for (int k = 0; k < 40 && v[0] !== 1'b0; k++) rd(OFS_STATUS, v);
    if (ok) tagExp++;
    nGo += ok;
    if (ok && w) lastCode = c;
    chk("status", {!ok, lastCode, 1'b0}, v[4:0]);
    rd(OFS_IRQ_STAT, v);
    st = {!ok, ok && w && c != 3'h0, ok};
    chk("irq status", st, v[2:0]);
    chk("irq", |(st & irqEn), irq);
    wr(OFS_IRQ_EN, 32'h0);
    wr(OFS_IRQ_EN, {29'h0, irqEn});
    wr(OFS_IRQ_CLR, 32'h7);
    rd(OFS_IRQ_STAT, v);
    chk("irq clear", 3'h0, v[2:0]);
  endtask
  task automatic complete_run();
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // ----------------------------------------
  // Request monitor and watchdog
  // ----------------------------------------
  always @(posedge clk) begin
    if (nrst && vcReqValid && vcReqReady) begin
      nAcc++;
      chk("request", reqExp, vcReq);
    end
  end
  initial begin
    #80000;
    n_mismatch++;
    complete_run();
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    logic [31:0] v;
    logic [31:0] g;
    logic [2:0]  c;
    {nrst, regAddr, regWdata, regWrite, regRead, slow, cplCode} = '0;
    {n_mismatch, n_compared, nGo, nAcc} = '0;
    {tagExp, lastCode, irqEn} = '0;
    lfsr = 16'hF2E9;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    for (int k = 0; k < 9; k++) begin
      rd(8'(4 * k), v);
      chk("reset value", k == 2 ? 32'h4 : 32'h0, v);
    end
    op(32'h0102_3403, 3'h1, 32'hA5A5_A5C3, 1'b1, CPL_UR);
    op(32'hFFFF_FFFC, 3'h4, 32'h1234_5678, 1'b0, CPL_SC);
    op(32'h0000_0003, 3'h2, 32'h5555_AAAA, 1'b1, CPL_SC);
    op(32'h0000_0001, 3'h0, 32'h1, 1'b1, CPL_SC);
    op(32'h0000_0000, 3'h5, 32'h1, 1'b0, CPL_SC);
    wr(OFS_IRQ_EN, 32'h7);
    irqEn = 3'h7;
    for (int i = 0; i < 24; i++) begin
      g = {rnd(), rnd()};
      v = {rnd(), rnd()};
      slow <= g[10];
      c = g[13] ? codes[g[12:11]] : CPL_SC;
      op(g, 3'(1 + g[15:14] % (4 - g[1:0])), v, g[13], c);
    end
    chk("accepted", 72'(nGo), 72'(nAcc));
    complete_run();
  end
endmodule // test_config_write_requester

// File: tb/vc_partner.sv
/* Target model: takes requests promptly or with stalls and returns
   one completion per request. Assumes the requester's clock. */
`timescale 1ns/10ps
module vc_partner
  import cfg_write_pkg::*;
(
  input  wire logic                    clk,
  input  wire logic                    nrst,
  input  wire logic                    slow,
  input  wire logic [2:0]              cplCode,
  input  wire logic                    vcReqValid,
  input  wire cfg_write_pkg::cfg_req_t vcReq,
  output      logic                    vcReqReady,
  output      logic                    vcCplValid,
  output      cfg_write_pkg::cfg_cpl_t vcCpl
);
  logic [7:0] noise;
  logic [7:0] tag_r;
  logic [3:0] wait_r;
  logic       owe;
  assign vcReqReady = slow ? noise[0] : 1'b1;
  always @(posedge clk) begin
    noise <= nrst ? noise * 8'h05 + 8'h3B : 8'h00;
    vcCplValid <= 1'b0;
    // Idle completion bus carries a moving pattern
    vcCpl <= {noise, noise[2:0]};
    if (!nrst) begin
      owe <= 1'b0;
    end else if (vcReqValid && vcReqReady) begin
      owe <= 1'b1;
      tag_r <= vcReq.tag;
      wait_r <= slow ? 4'h9 : 4'h2;
    end else if (owe && wait_r != 4'h0) begin
      wait_r <= wait_r - 4'h1;
    end else if (owe) begin
      owe <= 1'b0;
      vcCplValid <= 1'b1;
      vcCpl <= {tag_r, cplCode};
    end
  end
endmodule // vc_partner
